// file: rtl/led_fault_shutdown_ctrl.sv
`timescale 1ns/1ps
`include "led_fault_defs.svh"

// Summary of operation
// - Sinks conduct only while enable and dim input are both high.
// - Enable low beyond the long-low delay puts the part to sleep.
// - The enable rise after sleep clears faults, soft start follows dim.
// - Dim low beyond the delay with enable high clears faults only.
// - After a dim long-low clear, soft start runs on the next dim rise.
// - Bias and sync clock stay on whenever enable is high.
// - Fault pin is open drain, pulled low on fault, else released.
// - In one-out-all-out, external low beyond 8 switch cycles stops all.
// - A sink pin above the short threshold loses its current sink.
// - Standard variant disables only the shorted string and flags fault.
// - Standard short fault stays latched until a fault reset.
// - One-out-all-out short turns off all strings, fault latched.
// - Short detect is armed only while some sink pin is in regulation.
module led_fault_shutdown_ctrl
  import led_fault_pkg::*;
#(
  parameter int unsigned LONG_LOW_CYC = `LONG_LOW_CYCLES,
  parameter bit          ONE_OUT_ALL  = 1'b0
) (
  input  wire logic                       ref_clk,
  input  wire logic                       srst,
  input  wire logic                       clk_en,
  input  wire logic                       enable_pin,
  input  wire logic                       dim_pin,
  input  wire logic                       sw_tick,
  input  wire led_fault_pkg::sink_sense_t sense_pin,
  input  wire logic                       fault_in,
  output logic                            fault_out,
  output logic                            fault_oe,
  output logic [3:0]                      sink_on,
  output logic                            boost_on,
  output logic                            bias_on,
  output logic                            sync_clock_output_en,
  output logic                            soft_start_req
);
  import led_fault_pkg::*;

  // Two-flop synchronisers for all pin inputs
  logic [11:0] sync1_r;
  logic [11:0] sync2_r;
  wire  [11:0] raw = {fault_in, sense_pin, dim_pin, enable_pin, sw_tick};

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync1_r <= 12'h000;
      sync2_r <= 12'h000;
    end else if (clk_en) begin
      sync1_r <= raw;
      sync2_r <= sync1_r;
    end
  end

  wire         en_s    = sync2_r[1];
  wire         dim_s   = sync2_r[2];
  wire [3:0]   reg_s   = sync2_r[6:3];
  wire [3:0]   short_s = sync2_r[10:7];
  wire         ext_f_s = sync2_r[11];
  wire         tick_s  = sync2_r[0];

  // Timers and state
  logic [31:0] en_low_r;
  logic [31:0] dim_low_r;
  logic [3:0]  ext_cnt_r;
  logic        tick_d_r;
  logic        en_d_r;
  logic        dim_d_r;
  logic [3:0]  dis_r;
  logic        short_lat_r;
  pwr_state_t  state_r;
  pwr_state_t  state_nxt;

  wire tick_rise  = tick_s & ~tick_d_r;
  wire en_expire  = ~en_s & (en_low_r == LONG_LOW_CYC - 1);
  wire dim_expire = en_s & ~dim_s
                  & (dim_low_r == LONG_LOW_CYC - 1);
  wire en_rise    = en_s & ~en_d_r;
  wire dim_rise   = dim_s & ~dim_d_r;
  // Fault reset: wake from sleep or dim long-low
  wire fault_clr  = (state_r == SLEEP & en_rise) | dim_expire;
  wire armed      = |reg_s;
  wire running    = state_r != SLEEP & en_s & dim_s;
  wire [3:0] new_short = short_s & {4{armed & running}};
  wire ext_fault  = ONE_OUT_ALL & (ext_cnt_r > 4'(`EXT_FAULT_SW_CYC));
  wire own_fault  = short_lat_r;

  // Power state sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SLEEP:      if (en_rise) state_nxt = SOFT_START;
      SOFT_START: if (en_expire) state_nxt = SLEEP;
                  else if (dim_s) state_nxt = RUN;
      RUN:        if (en_expire) state_nxt = SLEEP;
                  else if (dim_expire) state_nxt = SOFT_START;
      default:    state_nxt = SLEEP;                   // Unused code
    endcase
  end

  // Low timers restart on every return high
  // Enable timer parks at its end count so sleep holds without wrap
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      en_low_r  <= 32'h0;
      dim_low_r <= 32'h0;
    end else if (clk_en) begin
      en_low_r  <= en_s ? 32'h0
                 : (en_expire ? en_low_r : en_low_r + 32'h1);
      dim_low_r <= (dim_s | ~en_s) ? 32'h0
                 : (dim_expire ? 32'h0 : dim_low_r + 32'h1);
    end
  end

  // External fault low counted in switching cycles
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ext_cnt_r <= 4'h0;
      tick_d_r  <= 1'b0;
    end else if (clk_en) begin
      tick_d_r <= tick_s;
      // Own pull-down is excluded so we do not trip ourselves
      if (ext_f_s | fault_oe)
        ext_cnt_r <= 4'h0;
      else if (tick_rise & ~ext_fault)
        ext_cnt_r <= ext_cnt_r + 4'h1;
    end
  end

  // Per-string disable flags and latched short fault
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dis_r       <= 4'h0;
      short_lat_r <= 1'b0;
      state_r     <= SLEEP;
      en_d_r      <= 1'b0;
      dim_d_r     <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      en_d_r  <= en_s;
      dim_d_r <= dim_s;
      if (fault_clr) begin
        dis_r       <= 4'h0;
        short_lat_r <= 1'b0;
      end else if (|new_short) begin
        dis_r       <= ONE_OUT_ALL ? 4'hF
                                   : (dis_r | new_short);
        short_lat_r <= 1'b1;
      end
    end
  end

  // Sink, boost and pin drive
  wire stop_all = ext_fault | (ONE_OUT_ALL & short_lat_r);
  wire [3:0] sink_nxt = {4{running & ~stop_all}} & ~dis_r;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sink_on              <= 4'h0;
      boost_on             <= 1'b0;
      bias_on              <= 1'b0;
      sync_clock_output_en <= 1'b0;
      fault_oe             <= 1'b0;
      soft_start_req       <= 1'b0;
    end else if (clk_en) begin
      sink_on              <= sink_nxt;
      boost_on             <= running & ~stop_all & (sink_nxt != 4'h0);
      bias_on              <= state_nxt != SLEEP;
      sync_clock_output_en <= state_nxt != SLEEP;
      fault_oe             <= own_fault;
      soft_start_req       <= state_r == SOFT_START & dim_s;
    end
  end

  // Open drain: data stays low, only the enable moves the wire
  assign fault_out = 1'b0;

  // Checks; a frozen cycle is judged only by the freeze check
  sink_gate_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    clk_en & (~en_s | ~dim_s) |=> sink_on == 4'h0)
    else $error("sink on without enable and dim");
  bias_hold_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    clk_en & en_s & state_r != SLEEP |=> bias_on)
    else $error("bias dropped while enabled");
  sleep_entry_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    clk_en & en_expire & state_r != SLEEP |=> state_r == SLEEP)
    else $error("no sleep after long enable low");
  dim_clear_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    clk_en & dim_expire |=> dis_r == 4'h0 && state_r != SLEEP)
    else $error("dim long low did not clear");
  short_latch_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    short_lat_r & clk_en & ~fault_clr |=> short_lat_r)
    else $error("short fault not latched");
  short_drop_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    clk_en & ~fault_clr & (|new_short) & ~ONE_OUT_ALL
      |=> ##1 !$past(clk_en) || (sink_on & $past(new_short, 2)) == 4'h0)
    else $error("shorted string still driven");
  fault_pin_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    clk_en & short_lat_r |=> fault_oe && fault_out == 1'b0)
    else $error("fault pin not pulled");
  ext_stop_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    clk_en & ext_fault |=> sink_on == 4'h0 && !boost_on)
    else $error("external fault ignored");
  disarm_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    clk_en & ~armed & ~fault_clr |=> $stable(dis_r))
    else $error("short detect while disarmed");
  dim_restart_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    clk_en & dim_rise & state_r == SOFT_START |=> soft_start_req)
    else $error("no soft start on dim rise");
  freeze_hold_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ~clk_en |=> $stable(dim_low_r) && $stable(sink_on))
    else $error("state moved while clock enable low");
endmodule : led_fault_shutdown_ctrl

// file: rtl/led_fault_defs.svh
`ifndef LED_FAULT_DEFS_SVH
`define LED_FAULT_DEFS_SVH

// Clock period in ns and documented delays
`define CLK_PERIOD_NS      10
`define LONG_LOW_MS        16
`define LONG_LOW_CYCLES    ((`LONG_LOW_MS * 1000000) / `CLK_PERIOD_NS)
`define EXT_FAULT_SW_CYC   8
`define NUM_STRINGS        4

`endif

// file: rtl/led_fault_pkg.sv
package led_fault_pkg;
  // Pin-level analog comparator results per string
  typedef struct packed {
    logic [3:0] above_short;   // Sink pin above sink_short_threshold
    logic [3:0] in_regulation; // Sink pin in current regulation
  } sink_sense_t;

  typedef enum logic [1:0] {
    SLEEP,
    SOFT_START,
    RUN
  } pwr_state_t;
endpackage : led_fault_pkg

// file: tb/fault_line_model.sv
`timescale 1ns/1ps
// Shared open-drain fault wire: pull-up, any pulling party wins
module fault_line_model (
  input  wire logic oe_a,
  input  wire logic oe_b,
  input  wire logic peer_pull,
  output logic      line_lvl
);
  assign line_lvl = ~(oe_a | oe_b | peer_pull);
endmodule : fault_line_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import led_fault_pkg::*;
  logic        ref_clk, srst, en, dim, tick, peer, line_lvl, ce;
  sink_sense_t sense;
  logic        fo_a, oe_a, oe_b, boost_a, boost_b, bias_a, sync_a, ss_a;
  logic [3:0]  sink_a, sink_b;
  int          miscompares, comparisons;

  // Standard variant and one-out-all-out variant on one fault wire
  led_fault_shutdown_ctrl #(.LONG_LOW_CYC(20), .ONE_OUT_ALL(1'b0)) uut (
    .ref_clk(ref_clk), .srst(srst), .clk_en(ce), .enable_pin(en),
    .dim_pin(dim), .sw_tick(tick), .sense_pin(sense), .fault_in(line_lvl),
    .fault_out(fo_a), .fault_oe(oe_a), .sink_on(sink_a), .boost_on(boost_a),
    .bias_on(bias_a), .sync_clock_output_en(sync_a), .soft_start_req(ss_a));
  led_fault_shutdown_ctrl #(.LONG_LOW_CYC(20), .ONE_OUT_ALL(1'b1)) uut_b (
    .ref_clk(ref_clk), .srst(srst), .clk_en(ce), .enable_pin(en),
    .dim_pin(dim), .sw_tick(tick), .sense_pin(sense), .fault_in(line_lvl),
    .fault_out(), .fault_oe(oe_b), .sink_on(sink_b), .boost_on(boost_b),
    .bias_on(), .sync_clock_output_en(), .soft_start_req());
  fault_line_model wire_m (
    .oe_a(oe_a), .oe_b(oe_b), .peer_pull(peer), .line_lvl(line_lvl));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  // Slow switching ticks, four reference cycles each
  task automatic ticks(input int n);
    repeat (n) begin
      tick = 1'b1;
      cyc(2);
      tick = 1'b0;
      cyc(2);
    end
  endtask : ticks

  task automatic t_run();
    en = 1'b1;
    dim = 1'b1;
    cyc(12);
    chk(sink_a, 4'hF);
    chk({3'h0, fo_a}, 4'h0);
    chk({3'h0, boost_a}, 4'h1);
    dim = 1'b0;
    cyc(5);
    chk(sink_a, 4'h0);
    chk({3'h0, boost_a}, 4'h0);
    chk({2'h0, bias_a, sync_a}, 4'h3);
    dim = 1'b1;
    cyc(8);
  endtask : t_run

  task automatic t_short();
    sense = {4'h2, 4'hD};
    cyc(6);
    chk(sink_a, 4'hD);
    chk({3'h0, oe_a}, 4'h1);
    chk(sink_b, 4'h0);
    sense = {4'h0, 4'hF};
    cyc(6);
    chk(sink_a, 4'hD);
  endtask : t_short

  // Frozen cycles must not count towards a long dim low
  task automatic t_freeze();
    ce = 1'b0;
    dim = 1'b0;
    cyc(30);
    chk(sink_a, 4'hD);
    ce = 1'b1;
    cyc(10);
    dim = 1'b1;
    cyc(6);
    chk({3'h0, oe_a}, 4'h1);
  endtask : t_freeze

  // Short dim low must not clear, long one must
  task automatic t_dim_clear();
    dim = 1'b0;
    cyc(15);
    dim = 1'b1;
    cyc(6);
    chk({3'h0, oe_a}, 4'h1);
    dim = 1'b0;
    cyc(30);
    chk({3'h0, oe_a}, 4'h0);
    chk({3'h0, bias_a}, 4'h1);
    dim = 1'b1;
    cyc(3);
    chk({3'h0, ss_a}, 4'h1);
    cyc(9);
    chk(sink_a, 4'hF);
    chk(sink_b, 4'hF);
  endtask : t_dim_clear

  task automatic t_no_arm();
    sense = {4'hF, 4'h0};
    cyc(6);
    chk(sink_a, 4'hF);
    sense = {4'h0, 4'hF};
  endtask : t_no_arm

  task automatic t_ext();
    peer = 1'b1;
    ticks(5);
    peer = 1'b0;
    cyc(4);
    chk(sink_b, 4'hF);
    peer = 1'b1;
    ticks(12);
    chk({3'h0, boost_b}, 4'h0);
    chk(sink_b, 4'h0);
    chk(sink_a, 4'hF);
    peer = 1'b0;
  endtask : t_ext

  // Latch a short, two short enable lows, then sleep and wake
  task automatic t_sleep();
    sense = {4'h2, 4'hD};
    cyc(6);
    chk(sink_a, 4'hD);
    sense = {4'h0, 4'hF};
    repeat (2) begin
      en = 1'b0;
      cyc(15);
      en = 1'b1;
      cyc(5);
    end
    chk({3'h0, bias_a}, 4'h1);
    en = 1'b0;
    cyc(40);
    chk({2'h0, bias_a, sync_a}, 4'h0);
    en = 1'b1;
    cyc(14);
    chk({3'h0, oe_a}, 4'h0);
    chk(sink_a, 4'hF);
    chk(sink_b, 4'hF);
  endtask : t_sleep

  task automatic end_sim();
    $display("checks %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // Run is a few hundred cycles; the limit leaves ample room
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end

  initial begin
    {srst, en, dim, tick, peer, ce} = 6'h21;
    sense = {4'h0, 4'hF};
    cyc(12);
    srst = 1'b0;
    t_run();
    t_short();
    t_freeze();
    t_dim_clear();
    t_no_arm();
    t_ext();
    t_sleep();
    end_sim();
  end
endmodule : testbench
